// ===== common/pulse_out_pkg.sv
// shared constants for the divided encoder pulse output block
package pulse_out_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MAX_EDGE_HZ = 4_000_000;
  localparam int unsigned EDGE_MIN_CYC = (CLK_HZ + MAX_EDGE_HZ - 1) / MAX_EDGE_HZ;
  // ------------------------------------------------------------
  // register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENC_RES = 8'h04;
  localparam logic [7:0] OFS_PULSES = 8'h08;
  localparam logic [7:0] OFS_DENOM = 8'h0c;
  localparam logic [7:0] OFS_MON_SEL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SRC_BIT = 1;
  localparam int unsigned MON1_LSB = 0;
  localparam int unsigned MON2_LSB = 8;
  localparam int unsigned RATIO_W = 24;
  localparam int unsigned DELTA_W = 8;
  localparam int unsigned MON_W = 16;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [23:0] RST_ENC_RES = 24'h10_0000;
  localparam logic [23:0] RST_PULSES = 24'h00_09c4;
  localparam logic [23:0] RST_DENOM = 24'h00_2710;
  localparam logic [15:0] RST_MON_SEL = 16'h0100;
  localparam int unsigned FIFO_DEPTH = 8;
  typedef enum logic [3:0] {MON_SPEED, MON_TORQUE, MON_POS_ERR, MON_OFF} mon_kind_t;
endpackage : pulse_out_pkg

// ===== common/stream_if.sv
// valid/ready stream carrier between the block's own modules
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ===== rtl/delta_fifo.sv
// small fifo holding position deltas ahead of the divider
`timescale 1ns/1ps
module delta_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  stream_if.snk in_s,
  stream_if.src out_s,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("delta_fifo depth must be a power of two of at least 2");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic full_r;
  logic room_r;
  wire push = in_s.valid && !full_r;
  wire pop = out_s.ready && (count_r != '0);
  wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  // ready leaves straight from a flop so the top-level ready pin is registered
  assign in_s.ready = room_r;
  assign out_s.valid = (count_r != '0);
  assign out_s.data = mem[rd_ptr_r];
  assign full = full_r;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= in_s.data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      full_r <= 1'b0;
      room_r <= 1'b1;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r <= count_nxt;
      full_r <= (count_nxt == (AW+1)'(DEPTH));
      room_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule : delta_fifo

// ===== rtl/quad_edge_gen.sv
// quadrature state stepper with a least spacing between edges
`timescale 1ns/1ps
module quad_edge_gen #(
  parameter int MIN_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  stream_if.snk step_s,
  output logic qa,
  output logic qb
);
  localparam int GW = $clog2(MIN_CYC + 1);
  if (MIN_CYC < 1) begin : g_chk
    $error("quad_edge_gen needs a spacing of at least one cycle");
  end
  logic [1:0] phase_r;
  logic [GW-1:0] gap_r;
  logic [GW-1:0] since_r;
  wire take = step_s.valid && step_s.ready;
  // data 0 steps forward (a leads), 1 steps back (b leads)
  wire [1:0] phase_nxt = step_s.data[0] ? phase_r - 2'h1 : phase_r + 2'h1;
  assign step_s.ready = (gap_r == '0);
  assign qa = (phase_r == 2'h1) || (phase_r == 2'h2);
  assign qb = phase_r[1];
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase_r <= 2'h0;
      gap_r <= '0;
    end else if (take) begin
      phase_r <= phase_nxt;
      gap_r <= GW'(MIN_CYC - 1);
    end else if (gap_r != '0) begin
      gap_r <= gap_r - GW'(1);
    end
  end
  // helper: cycles since the last step, saturating
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      since_r <= GW'(MIN_CYC);
    end else if (take) begin
      since_r <= '0;
    end else if (since_r != GW'(MIN_CYC)) begin
      since_r <= since_r + GW'(1);
    end
  end
  a_edge_spacing: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take |-> since_r >= GW'(MIN_CYC - 1)) else $error("quadrature edges too close");
  a_one_phase_moves: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !($changed(qa) && $changed(qb))) else $error("a and b changed together");
  a_direction_lead: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && !step_s.data[0] |=> phase_r == $past(phase_r) + 2'h1)
    else $error("forward step did not advance the phase");
endmodule : quad_edge_gen

// ===== rtl/pulse_divider_out.sv
// divided a/b/z pulse output and monitor selection with an apb register file
//
// How it works
// - divided encoder or scale position drives differential a/b/z
// - edge spacing keeps quadrupled rate at most 4 Mpps
// - z follows a-high when product is multiple of four times denom
// - otherwise z lasts one count of the selected source
// - sequence may be irregular before first index
// - single-ended index output mirrors differential index
// - torque monitor follows monitor 2 select, equals front 2
// - speed monitor follows monitor 1 select, equals front 1
`timescale 1ns/1ps
module pulse_divider_out (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pulse_out_pkg::DELTA_W-1:0] enc_delta,
  input wire logic enc_delta_valid,
  input wire logic [pulse_out_pkg::DELTA_W-1:0] scale_delta,
  input wire logic scale_delta_valid,
  output logic delta_ready,
  input wire logic enc_index_pin,
  input wire logic scale_index_pin,
  input wire logic [pulse_out_pkg::MON_W-1:0] speed_value,
  input wire logic [pulse_out_pkg::MON_W-1:0] torque_value,
  input wire logic [pulse_out_pkg::MON_W-1:0] pos_err_value,
  output logic a_phase_out_pos,
  output logic a_phase_out_neg,
  output logic b_phase_out_pos,
  output logic b_phase_out_neg,
  output logic index_out_pos,
  output logic index_out_neg,
  output logic index_out_single,
  output logic index_out_single_oe_b,
  output logic [pulse_out_pkg::MON_W-1:0] torque_monitor_out,
  output logic [pulse_out_pkg::MON_W-1:0] speed_monitor_out,
  output logic [pulse_out_pkg::MON_W-1:0] front_monitor1_out,
  output logic [pulse_out_pkg::MON_W-1:0] front_monitor2_out
);
  import pulse_out_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [MON_W-1:0] mon_pick(input logic [3:0] sel,
                                                 input logic [MON_W-1:0] spd,
                                                 input logic [MON_W-1:0] trq,
                                                 input logic [MON_W-1:0] perr);
    logic [MON_W-1:0] v;
    v = '0;
    unique case (mon_kind_t'(sel))
      MON_SPEED: v = spd;
      MON_TORQUE: v = trq;
      MON_POS_ERR: v = perr;
      MON_OFF: v = '0;
      default: v = '0;
    endcase
    return v;
  endfunction : mon_pick

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic [RATIO_W-1:0] enc_res_r;
  logic [RATIO_W-1:0] pulses_r;
  logic [RATIO_W-1:0] denom_r;
  logic [15:0] mon_sel_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic aligned_r;
  logic index_seen_r;
  logic fifo_full;

  wire setup_ph = psel && !penable;
  wire wr_take = psel && penable && pready_r && pwrite;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_res = (paddr == OFS_ENC_RES);
  wire hit_pulses = (paddr == OFS_PULSES);
  wire hit_denom = (paddr == OFS_DENOM);
  wire hit_mon = (paddr == OFS_MON_SEL);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_any = hit_ctrl | hit_res | hit_pulses | hit_denom | hit_mon | hit_status;
  wire src_scale = ctrl_r[CTRL_SRC_BIT];
  wire den_ok = (denom_r != '0);
  wire active = ctrl_r[CTRL_EN_BIT] && den_ok;
  logic qa;
  logic qb;
  logic z_r;
  wire [31:0] status_w = {26'h0, qb, qa, z_r, fifo_full, aligned_r, index_seen_r};
  wire [31:0] rd_mux =
      hit_ctrl ? {30'h0, ctrl_r} :
      hit_res ? {8'h0, enc_res_r} :
      hit_pulses ? {8'h0, pulses_r} :
      hit_denom ? {8'h0, denom_r} :
      hit_mon ? {16'h0, mon_sel_r} :
      hit_status ? status_w : 32'h0;

  // answer in the first access cycle; writes land at that edge
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph && !hit_any;
      prdata_r <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_r <= RST_CTRL;
      enc_res_r <= RST_ENC_RES;
      pulses_r <= RST_PULSES;
      denom_r <= RST_DENOM;
      mon_sel_r <= RST_MON_SEL;
    end else if (wr_take) begin
      if (hit_ctrl) ctrl_r <= pwdata[1:0];
      if (hit_res) enc_res_r <= pwdata[RATIO_W-1:0];
      if (hit_pulses) pulses_r <= pwdata[RATIO_W-1:0];
      if (hit_denom) denom_r <= pwdata[RATIO_W-1:0];
      if (hit_mon) mon_sel_r <= pwdata[15:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ------------------------------------------------------------
  // index pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] enc_idx_sync_r;
  logic [1:0] scale_idx_sync_r;
  logic idx_prev_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      enc_idx_sync_r <= 2'b00;
      scale_idx_sync_r <= 2'b00;
      idx_prev_r <= 1'b0;
    end else begin
      enc_idx_sync_r <= {enc_idx_sync_r[0], enc_index_pin};
      scale_idx_sync_r <= {scale_idx_sync_r[0], scale_index_pin};
      idx_prev_r <= src_scale ? scale_idx_sync_r[1] : enc_idx_sync_r[1];
    end
  end
  wire idx_level = src_scale ? scale_idx_sync_r[1] : enc_idx_sync_r[1];
  wire idx_rise = active && idx_level && !idx_prev_r;

  // ------------------------------------------------------------
  // source select and delta fifo
  // ------------------------------------------------------------
  stream_if #(.W(DELTA_W)) in_s ();
  stream_if #(.W(DELTA_W)) out_s ();
  assign in_s.valid = src_scale ? scale_delta_valid : enc_delta_valid;
  assign in_s.data = src_scale ? scale_delta : enc_delta;

  delta_fifo #(.W(DELTA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_s(in_s),
    .out_s(out_s),
    .full(fifo_full)
  );
  // ready is the fifo's registered not-full
  assign delta_ready = in_s.ready;

  // ------------------------------------------------------------
  // divider: acc gains delta*pulses, loses denom per forward edge, gains denom per reverse edge
  // ------------------------------------------------------------
  localparam int ACC_W = RATIO_W + DELTA_W + 3;
  logic signed [ACC_W-1:0] acc_r;
  stream_if #(.W(1)) step_s ();
  wire signed [ACC_W-1:0] den_s = ACC_W'($signed({1'b0, denom_r}));
  wire signed [ACC_W-1:0] scaled =
      ACC_W'($signed(out_s.data)) * ACC_W'($signed({1'b0, pulses_r}));
  wire step_fwd = active && (acc_r >= den_s);
  wire step_rev = active && (acc_r <= -den_s);
  wire need_step = step_fwd || step_rev;
  wire step_take = step_s.valid && step_s.ready;
  // pops stall while an edge is owed, so the fifo backs up
  assign out_s.ready = !active || !need_step;
  wire pop = out_s.valid && out_s.ready && active;
  wire count_seen = pop && (out_s.data != '0);
  assign step_s.valid = need_step;
  assign step_s.data = step_rev;

  always_ff @(posedge clk_sys) begin
    if (!rst_b || !active) begin
      acc_r <= '0;
    end else if (step_take) begin
      acc_r <= step_rev ? acc_r + den_s : acc_r - den_s;
    end else if (pop) begin
      acc_r <= acc_r + scaled;
    end
  end

  quad_edge_gen #(.MIN_CYC(EDGE_MIN_CYC)) u_quad (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .step_s(step_s),
    .qa(qa),
    .qb(qb)
  );

  // ------------------------------------------------------------
  // index shaping
  // ------------------------------------------------------------
  wire [2*RATIO_W-1:0] prod = enc_res_r * pulses_r;
  wire [RATIO_W+1:0] den4 = {denom_r, 2'b00};
  wire mult4_w = den_ok && ((prod % (2*RATIO_W)'(den4)) == '0);
  logic qa_d_r;
  logic qb_d_r;
  logic zarm_r;
  wire a_rise = qa && !qa_d_r;
  wire a_fall = !qa && qa_d_r;
  logic z_nxt;
  logic zarm_nxt;
  always_comb begin
    z_nxt = z_r;
    zarm_nxt = zarm_r;
    if (!active) begin
      z_nxt = 1'b0;
      zarm_nxt = 1'b0;
    end else if (aligned_r) begin
      if (z_r && a_fall) z_nxt = 1'b0;
      if (zarm_r && a_rise) begin
        z_nxt = 1'b1;
        zarm_nxt = 1'b0;
      end
      if (idx_rise) zarm_nxt = 1'b1;
    end else begin
      zarm_nxt = 1'b0;
      if (count_seen) z_nxt = 1'b0;
      if (idx_rise) z_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      qa_d_r <= 1'b0;
      qb_d_r <= 1'b0;
      z_r <= 1'b0;
      zarm_r <= 1'b0;
      aligned_r <= 1'b0;
      index_seen_r <= 1'b0;
    end else begin
      qa_d_r <= qa;
      qb_d_r <= qb;
      z_r <= z_nxt;
      zarm_r <= zarm_nxt;
      aligned_r <= mult4_w;
      index_seen_r <= active && (index_seen_r || z_r);
    end
  end

  // ------------------------------------------------------------
  // output drivers and monitors
  // ------------------------------------------------------------
  wire [MON_W-1:0] mon1_w = mon_pick(mon_sel_r[MON1_LSB +: 4], speed_value,
                                     torque_value, pos_err_value);
  wire [MON_W-1:0] mon2_w = mon_pick(mon_sel_r[MON2_LSB +: 4], speed_value,
                                     torque_value, pos_err_value);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      a_phase_out_pos <= 1'b0;
      a_phase_out_neg <= 1'b1;
      b_phase_out_pos <= 1'b0;
      b_phase_out_neg <= 1'b1;
      index_out_pos <= 1'b0;
      index_out_neg <= 1'b1;
      index_out_single <= 1'b0;
      index_out_single_oe_b <= 1'b1;
      speed_monitor_out <= '0;
      torque_monitor_out <= '0;
      front_monitor1_out <= '0;
      front_monitor2_out <= '0;
    end else begin
      a_phase_out_pos <= qa_d_r;
      a_phase_out_neg <= !qa_d_r;
      b_phase_out_pos <= qb_d_r;
      b_phase_out_neg <= !qb_d_r;
      index_out_pos <= z_r;
      index_out_neg <= !z_r;
      // open collector: pulled low while the index is active
      index_out_single <= 1'b0;
      index_out_single_oe_b <= !z_r;
      speed_monitor_out <= mon1_w;
      front_monitor1_out <= mon1_w;
      torque_monitor_out <= mon2_w;
      front_monitor2_out <= mon2_w;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_diff_pairs: assert property (@(posedge clk_sys) disable iff (!rst_b)
    a_phase_out_neg == !a_phase_out_pos && b_phase_out_neg == !b_phase_out_pos)
    else $error("differential a/b pair not complementary");
  a_single_index: assert property (@(posedge clk_sys) disable iff (!rst_b)
    index_out_single_oe_b == !index_out_pos && index_out_neg == !index_out_pos
    && !index_out_single) else $error("single index differs from pair");
  a_z_with_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    aligned_r && $rose(z_r) |-> $rose(qa_d_r)) else $error("aligned index off a edge");
  a_z_held_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    aligned_r && $stable(aligned_r) && z_r |-> qa_d_r) else $error("index outside a high");
  a_z_narrow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !aligned_r && active && z_r && count_seen && !idx_rise |=> !z_r)
    else $error("narrow index outlived one count");
  a_index_seen: assert property (@(posedge clk_sys) disable iff (!rst_b)
    active && z_r |=> ##1 index_seen_r) else $error("first index not recorded");
  a_mon1_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> speed_monitor_out == $past(mon1_w) && front_monitor1_out == speed_monitor_out)
    else $error("speed monitor mismatch");
  a_mon2_sel: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> torque_monitor_out == $past(mon2_w) && front_monitor2_out == torque_monitor_out)
    else $error("torque monitor mismatch");
  a_step_waits: assert property (@(posedge clk_sys) disable iff (!rst_b)
    need_step && !step_s.ready |=> $stable(acc_r)) else $error("step lost under spacing");
endmodule : pulse_divider_out

// ===== bench/quad_host_model.sv
// host-side quadrature counter watching the divided pulse outputs
`timescale 1ns/1ps
module quad_host_model #(
  parameter int MIN_GAP = 50
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic a_phase_out_pos,
  input wire logic a_phase_out_neg,
  input wire logic b_phase_out_pos,
  input wire logic b_phase_out_neg,
  input wire logic index_out_pos,
  input wire logic index_out_neg,
  input wire logic index_out_single,
  input wire logic index_out_single_oe_b,
  input wire logic aligned_mode,
  output int count,
  output int bad_cnt,
  output logic index_seen
);
  // ------------------------------------------------------------
  // decode and line checks
  // ------------------------------------------------------------
  logic [1:0] prev_r;
  int gap_r;
  wire logic [1:0] cur = {a_phase_out_pos, b_phase_out_pos};
  wire logic moved = cur != prev_r;
  function automatic logic [1:0] step_fwd(input logic [1:0] s);
    case (s)
      2'b00: step_fwd = 2'b10;
      2'b10: step_fwd = 2'b11;
      2'b11: step_fwd = 2'b01;
      default: step_fwd = 2'b00;
    endcase
  endfunction : step_fwd
  wire logic is_fwd = step_fwd(prev_r) == cur;
  wire logic is_rev = step_fwd(cur) == prev_r;
  wire logic e_gap = moved && gap_r < MIN_GAP;
  wire logic e_seq = moved && !is_fwd && !is_rev;
  wire logic e_pair = a_phase_out_neg !== ~a_phase_out_pos || b_phase_out_neg !== ~b_phase_out_pos
    || index_out_neg !== ~index_out_pos;
  wire logic e_single = index_out_single !== 1'b0 || index_out_single_oe_b !== ~index_out_pos;
  wire logic e_align = aligned_mode && index_out_pos && !a_phase_out_pos;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      prev_r <= 2'b00;
      gap_r <= MIN_GAP;
      count <= 0;
      bad_cnt <= 0;
      index_seen <= 1'b0;
    end else begin
      prev_r <= cur;
      gap_r <= moved ? 1 : gap_r + 1;
      count <= count + (moved && is_fwd ? 1 : 0) - (moved && is_rev ? 1 : 0);
      bad_cnt <= bad_cnt + e_gap + e_seq + e_pair + e_single + e_align;
      // counts are trusted only once an index has been seen
      if (index_out_pos) index_seen <= 1'b1;
    end
  end
endmodule : quad_host_model

// ===== bench/pulse_divider_out_tb.sv
// self-checking bench for the divided pulse output block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pulse_divider_out_tb;
  import pulse_out_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b, psel, penable, pwrite, pready, pslverr, delta_ready, er, full_seen, aligned_r;
  logic [7:0] paddr, enc_delta, scale_delta;
  logic [31:0] pwdata, prdata, rd, d32;
  logic enc_delta_valid, scale_delta_valid, enc_index_pin, scale_index_pin;
  logic [15:0] speed_value, torque_value, pos_err_value, mon1, mon2, frnt1, frnt2;
  logic a_p, a_n, b_p, b_n, z_p, z_n, z_s, z_oe_b, index_seen;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 42194;
  int count, bad_cnt, exp_cnt, d;
  logic [7:0] ofs [6] = '{OFS_CTRL, OFS_ENC_RES, OFS_PULSES, OFS_DENOM, OFS_MON_SEL, OFS_STATUS};
  logic [31:0] rv [6] = '{32'(RST_CTRL), 32'(RST_ENC_RES), 32'(RST_PULSES), 32'(RST_DENOM),
    32'(RST_MON_SEL), 32'h2};
  always #2.5 clk_sys = ~clk_sys;
  pulse_divider_out dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_delta(enc_delta), .enc_delta_valid(enc_delta_valid),
    .scale_delta(scale_delta), .scale_delta_valid(scale_delta_valid), .delta_ready(delta_ready),
    .enc_index_pin(enc_index_pin), .scale_index_pin(scale_index_pin),
    .speed_value(speed_value), .torque_value(torque_value), .pos_err_value(pos_err_value),
    .a_phase_out_pos(a_p), .a_phase_out_neg(a_n), .b_phase_out_pos(b_p), .b_phase_out_neg(b_n),
    .index_out_pos(z_p), .index_out_neg(z_n), .index_out_single(z_s),
    .index_out_single_oe_b(z_oe_b), .torque_monitor_out(mon2), .speed_monitor_out(mon1),
    .front_monitor1_out(frnt1), .front_monitor2_out(frnt2));
  quad_host_model #(.MIN_GAP(EDGE_MIN_CYC)) host (.clk_sys(clk_sys), .rst_b(rst_b),
    .a_phase_out_pos(a_p), .a_phase_out_neg(a_n), .b_phase_out_pos(b_p), .b_phase_out_neg(b_n),
    .index_out_pos(z_p), .index_out_neg(z_n), .index_out_single(z_s),
    .index_out_single_oe_b(z_oe_b), .aligned_mode(aligned_r), .count(count),
    .bad_cnt(bad_cnt), .index_seen(index_seen));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic hang();
    num_errors++;
    finish_test();
  endtask : hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic push(input logic src, input int dv);
    int n;
    n = 0;
    enc_delta <= src ? 8'($random(seed)) : 8'(dv);
    enc_delta_valid <= src ? 1'($random(seed)) : 1'b1;
    scale_delta <= src ? 8'(dv) : 8'($random(seed));
    scale_delta_valid <= src ? 1'b1 : 1'($random(seed));
    do begin
      @(posedge clk_sys);
      n++;
      if (delta_ready !== 1'b1) full_seen = 1'b1;
    end while (delta_ready !== 1'b1 && n < 5000);
    if (n >= 5000) hang();
  endtask : push
  task automatic stop_push();
    enc_delta_valid <= 1'b0;
    scale_delta_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : stop_push
  // the count must settle on the target, not just pass through it
  task automatic wait_count();
    int n;
    int calm;
    calm = 0;
    for (n = 0; n < 8000 && calm < 100; n++) begin
      @(posedge clk_sys);
      calm = (count == exp_cnt) ? calm + 1 : 0;
    end
    if (n >= 8000) hang();
  endtask : wait_count
  task automatic index_pulse(input logic src);
    enc_index_pin <= !src;
    scale_index_pin <= src;
    repeat (4) @(posedge clk_sys);
    enc_index_pin <= 1'b0;
    scale_index_pin <= 1'b0;
  endtask : index_pulse
  function automatic logic [15:0] mon_exp(input int k);
    case (k)
      0: mon_exp = speed_value;
      1: mon_exp = torque_value;
      2: mon_exp = pos_err_value;
      default: mon_exp = 16'h0000;
    endcase
  endfunction : mon_exp
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {enc_delta, enc_delta_valid, scale_delta, scale_delta_valid} = '0;
    {enc_index_pin, scale_index_pin, speed_value, torque_value, pos_err_value} = '0;
    aligned_r = 1'b1;
    full_seen = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      `CHK(rd, rv[i])
    end
    apb(1'b0, 8'h18, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, OFS_STATUS, 32'hff);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd, 32'h2)
    d32 = $random(seed);
    apb(1'b1, OFS_PULSES, d32);
    apb(1'b0, OFS_PULSES, 32'h0);
    `CHK(rd, {8'h00, d32[23:0]})
    for (int k = 0; k < 5; k++) begin
      speed_value <= 16'($random(seed));
      torque_value <= 16'($random(seed));
      pos_err_value <= 16'($random(seed));
      apb(1'b1, OFS_MON_SEL, 32'(k) | (32'((k + 1) % 5) << MON2_LSB));
      repeat (3) @(posedge clk_sys);
      `CHK({mon1, frnt1}, {2{mon_exp(k)}})
      `CHK({mon2, frnt2}, {2{mon_exp((k + 1) % 5)}})
    end
    // one output edge per count, encoder source, aligned index
    apb(1'b1, OFS_PULSES, 32'h1);
    apb(1'b1, OFS_DENOM, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    index_pulse(1'b0);
    for (int i = 0; i < 4; i++) push(1'b0, 1);
    stop_push();
    exp_cnt = 4;
    wait_count();
    `CHK(count, exp_cnt)
    `CHK(index_seen, 1'b1)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[1:0], 2'b11)
    for (int i = 0; i < 12; i++) push(1'b0, 2);
    stop_push();
    `CHK(full_seen, 1'b1)
    exp_cnt += 24;
    wait_count();
    `CHK(count, exp_cnt)
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFS_CTRL, 32'(s) << CTRL_SRC_BIT | 32'h1);
      for (int i = 0; i < 16; i++) begin
        d = $random(seed) % 4;
        exp_cnt += d;
        push(1'(s), d);
      end
      stop_push();
      wait_count();
      `CHK(count, exp_cnt)
    end
    // odd product: index lasts until the next count
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_ENC_RES, 32'h10_0001);
    aligned_r = 1'b0;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[1], 1'b0)
    index_pulse(1'b0);
    repeat (10) @(posedge clk_sys);
    `CHK({z_p, z_oe_b}, 2'b10)
    push(1'b0, 1);
    stop_push();
    for (d = 0; d < 20 && z_p !== 1'b0; d++) @(posedge clk_sys);
    `CHK(z_p, 1'b0)
    exp_cnt += 1;
    wait_count();
    `CHK(count, exp_cnt)
    // scale source index takes the same narrow shaping
    apb(1'b1, OFS_CTRL, 32'h3);
    index_pulse(1'b1);
    repeat (10) @(posedge clk_sys);
    `CHK({z_p, z_oe_b}, 2'b10)
    push(1'b1, 1);
    stop_push();
    exp_cnt += 1;
    wait_count();
    `CHK({z_p, count}, {1'b0, exp_cnt})
    `CHK(bad_cnt, 0)
    finish_test();
  end
endmodule : pulse_divider_out_tb
